// [core/npec_checker.sv]
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
// Contract
// RL1 - writing one to clear-bit zeroes both codes
// RL2 - page select: 528, 1056, 2112, 4224 words
// RL3 - words are 8 or 16 bits wide
// RL4 - any page error sets recoverable flag
// RL5 - recoverable plus multiple means uncorrectable errors
// RL6 - single bad code bit sets code-error flag
// RL7 - code error shows one set bit
// RL8 - multiple flag follows multiple-error detection
// RL9 - host stores both codes in spare area
// RL10 - single error gives faulty bit offset
// RL11 - single error gives faulty word index
// RL12 - location meaningless after multiple errors
// RL13 - word index bits steer parity accumulation
// RL14 - one step per word, upper bits zero
module npec_checker (
    // clock, reset, enable
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // flash data path words
    input  wire logic        word_valid,
    input  wire logic [15:0] word_data,
    input  wire logic        wide_bus,
    // stored code read back from spare area
    input  wire logic        code_check,
    input  wire logic [15:0] stored_parity,
    input  wire logic [15:0] stored_inv_parity,
    // interrupt
    output logic             irq
);

    // module state, all but the reset synchroniser flops
    typedef struct packed {
        logic [1:0]  page_length_select; // page size code
        logic [15:0] parity;             // parity code
        logic [15:0] inverted_parity_value; // inverted parity
        logic [12:0] word_idx;           // words seen in page
        logic [2:0]  flags;              // error flags
        logic [2:0]  irq_stat;           // sticky events
        logic [2:0]  irq_mask;           // event enables
        logic        ack;                // bus acknowledge
        logic [31:0] rdata;              // read data
        logic        irq;                // interrupt level
    } npec_state_t;

    localparam npec_state_t STATE_RST = '{
        page_length_select:    npec_pkg::PAGE_CFG_RST,
        parity:                npec_pkg::PARITY_RST,
        inverted_parity_value: npec_pkg::PARITY_RST,
        flags:                 npec_pkg::FLAGS_RST,
        default:               '0
    };

    npec_state_t s_r;   // registered state
    npec_state_t s_nxt; // next state

    // synchronised reset
    logic [1:0] rst_pipe_r;
    logic       rst_sync_n;

    // release reset through two flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_r <= 2'b00;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe_r[1];

    // word data, upper byte dropped for 8-bit flash
    logic [15:0] data_w;
    logic        row_par;  // parity of whole word
    logic [3:0]  bit_mask; // bit-offset bits in use
    logic [3:0]  col_p;    // bit-index bit set
    logic [3:0]  col_n;    // bit-index bit clear
    logic [11:0] row_p;    // word-index bit set
    logic [11:0] row_n;    // word-index bit clear
    logic [15:0] acc_p;    // toggle pattern, parity
    logic [15:0] acc_n;    // toggle pattern, inverted
    logic        page_open;
    logic        take_word;

    assign data_w   = wide_bus ? word_data : {8'h00, word_data[7:0]}; // [RL3]
    assign row_par  = ^data_w;
    assign bit_mask = wide_bus ? npec_pkg::BIT_FIELD_WIDE
                               : npec_pkg::BIT_FIELD_NARROW; // [RL3]

    // per-bit column and row parities
    generate
        for (genvar k = 0; k < 4; k++) begin : g_col
            assign col_p[k] = ^(data_w & npec_pkg::COL_MASK[k]);
            assign col_n[k] = ^(data_w & ~npec_pkg::COL_MASK[k]);
        end
        for (genvar i = 0; i < 12; i++) begin : g_row
            // split by word index bit i [RL13]
            assign row_p[i] = row_par & s_r.word_idx[i];
            assign row_n[i] = row_par & ~s_r.word_idx[i];
        end
    endgenerate

    assign acc_p = {row_p, col_p & bit_mask};
    assign acc_n = {row_n, col_n & bit_mask};

    // only words inside the selected page count
    assign page_open = s_r.word_idx <
                       npec_pkg::PAGE_WORDS[s_r.page_length_select]; // [RL2]
    assign take_word = word_valid & page_open; // [RL14]

    // syndrome of computed against stored code
    logic [15:0] code_mask;
    logic [15:0] syn_p;
    logic [15:0] syn_n;
    logic [15:0] syn_all;
    logic [31:0] syn_cat;    // both syndromes side by side
    logic        err_none;
    logic        err_single;
    logic        err_code;
    logic        err_multi;
    logic [2:0]  new_flags;

    assign code_mask  = {npec_pkg::WORD_FIELD_MASK[s_r.page_length_select],
                         bit_mask};
    assign syn_p      = (s_r.parity ^ stored_parity) & code_mask;
    assign syn_n      = (s_r.inverted_parity_value ^ stored_inv_parity)
                        & code_mask;
    assign syn_all    = syn_p | syn_n;
    assign syn_cat    = {syn_n, syn_p};
    assign err_none   = (syn_all == 16'h0000);
    // data error flips exactly one of each pair [RL10] [RL11]
    assign err_single = ((syn_p ^ syn_n) == code_mask);
    // one stray bit over both codes means the stored code is hit [RL6] [RL7]
    // two data bits in one word can hit one position of each code
    assign err_code   = !err_none &&
                        ((syn_cat & (syn_cat - 32'h0000_0001)) == 32'h0000_0000);
    // anything else is beyond repair [RL8] [RL12]
    assign err_multi  = !err_none && !err_single && !err_code;

    // flag set from one check
    always_comb begin
        new_flags = 3'h0;
        new_flags[npec_pkg::FLAG_REC_BIT]  = !err_none;  // [RL4] [RL5]
        new_flags[npec_pkg::FLAG_CODE_BIT] = err_code;   // [RL6]
        new_flags[npec_pkg::FLAG_MUL_BIT]  = err_multi;  // [RL8]
    end

    // bus decode
    logic       req;
    logic       wr_go;
    logic [2:0] ev_set;
    logic [2:0] ev_clr;

    assign req   = wb_cyc_i & wb_stb_i;
    // write lands on the edge that sees ack
    assign wr_go = req & wb_we_i & s_r.ack & wb_sel_i[0];

    // next-state logic
    always_comb begin
        s_nxt  = s_r;
        ev_set = 3'h0;
        ev_clr = 3'h0;
        // one-cycle ack, dropped the cycle after
        s_nxt.ack = req & ~s_r.ack;
        // accumulate one word [RL13] [RL14]
        if (take_word) begin
            s_nxt.parity                = s_r.parity ^ acc_p;
            s_nxt.inverted_parity_value = s_r.inverted_parity_value ^ acc_n;
            s_nxt.word_idx              = s_r.word_idx + 13'h0001;
        end
        // check loads syndrome as location [RL10] [RL11]
        if (code_check) begin
            s_nxt.parity                = syn_p;
            s_nxt.inverted_parity_value = syn_n;
            s_nxt.flags                 = new_flags; // [RL8]
            ev_set                      = new_flags;
        end
        // register writes
        if (wr_go) begin
            case (wb_adr_i)
                npec_pkg::OFS_COMMAND: begin
                    // zero has no effect [RL1]
                    if (wb_dat_i[npec_pkg::CMD_CLEAR_BIT]) begin
                        s_nxt.parity                = npec_pkg::PARITY_RST; // [RL1]
                        s_nxt.inverted_parity_value = npec_pkg::PARITY_RST; // [RL1]
                        s_nxt.word_idx              = 13'h0000;
                        s_nxt.flags                 = npec_pkg::FLAGS_RST;
                    end
                end
                npec_pkg::OFS_PAGE_CFG: begin
                    s_nxt.page_length_select = wb_dat_i[1:0]; // [RL2]
                end
                npec_pkg::OFS_IRQ_STATUS: begin
                    ev_clr = wb_dat_i[2:0];
                end
                npec_pkg::OFS_IRQ_MASK: begin
                    s_nxt.irq_mask = wb_dat_i[2:0];
                end
                default: begin
                    // read-only or unmapped: ignored
                end
            endcase
        end
        // sticky events, a new event beats the clear
        s_nxt.irq_stat = (s_r.irq_stat & ~ev_clr) | ev_set;
        s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_mask);
        // read data valid while ack is high
        s_nxt.rdata = 32'h0000_0000;
        if (req && !wb_we_i && !s_r.ack) begin
            case (wb_adr_i)
                npec_pkg::OFS_PAGE_CFG:
                    s_nxt.rdata[1:0] = s_r.page_length_select;
                npec_pkg::OFS_FLAGS:
                    s_nxt.rdata[2:0] = s_r.flags;
                npec_pkg::OFS_PARITY:
                    s_nxt.rdata[15:0] = s_r.parity; // [RL14]
                npec_pkg::OFS_INV_PARITY:
                    s_nxt.rdata[15:0] = s_r.inverted_parity_value; // [RL14]
                npec_pkg::OFS_IRQ_STATUS:
                    s_nxt.rdata[2:0] = s_r.irq_stat;
                npec_pkg::OFS_IRQ_MASK:
                    s_nxt.rdata[2:0] = s_r.irq_mask;
                default:
                    s_nxt.rdata = 32'h0000_0000; // command, unmapped
            endcase
        end
    end

    // state register, frozen while clk_en is low
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_r <= STATE_RST;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops
    assign wb_dat_o = s_r.rdata;
    assign wb_ack_o = s_r.ack;
    assign irq      = s_r.irq;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_sync_n);

    a_clear_zeroes_codes: assert property ( // [RL1]
        clk_en && wr_go && wb_adr_i == npec_pkg::OFS_COMMAND && wb_dat_i[0]
        |=> s_r.parity == 16'h0000 && s_r.inverted_parity_value == 16'h0000)
        else $error("clear did not zero both codes");

    a_zero_write_inert: assert property ( // [RL1]
        clk_en && wr_go && wb_adr_i == npec_pkg::OFS_COMMAND && !wb_dat_i[0]
        && !take_word && !code_check |=> $stable(s_r.parity))
        else $error("writing zero changed parity");

    a_page_end_holds: assert property ( // [RL2]
        clk_en && word_valid && !page_open && !wr_go && !code_check
        |=> $stable(s_r.word_idx) && $stable(s_r.parity))
        else $error("word counted past page end");

    a_narrow_bit_three: assert property ( // [RL3]
        clk_en && take_word && !wide_bus && !code_check && !wr_go
        |=> s_r.parity[3] == $past(s_r.parity[3]))
        else $error("8-bit word touched offset bit 3");

    a_single_flags_set: assert property ( // [RL4]
        clk_en && code_check && err_single && !wr_go
        |=> s_r.flags == 3'b001)
        else $error("single error flags wrong");

    a_multi_flags_set: assert property ( // [RL5]
        clk_en && code_check && err_multi && !wr_go
        |=> s_r.flags == 3'b101)
        else $error("multiple error flags wrong");

    a_code_err_onehot: assert property ( // [RL7]
        clk_en && code_check && err_code && !wr_go
        |=> s_r.flags[1] && $onehot({s_r.parity, s_r.inverted_parity_value}))
        else $error("code error not a single bit");

    a_location_loaded: assert property ( // [RL11]
        clk_en && code_check && !wr_go
        |=> s_r.parity == $past(syn_p))
        else $error("syndrome not loaded");

    a_upper_bits_zero: assert property ( // [RL14]
        wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");

    a_ack_one_cycle: assert property (
        wb_ack_o && clk_en |=> !wb_ack_o)
        else $error("ack held two cycles");

    c_single_error: cover property (code_check && err_single);
    c_multi_error:  cover property (code_check && err_multi);
    c_code_error:   cover property (code_check && err_code);
    c_irq_raised:   cover property (!irq ##1 irq);

endmodule : npec_checker

// [core/npec_pkg.sv]
package npec_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_COMMAND    = 8'h00;
    localparam logic [7:0] OFS_PAGE_CFG   = 8'h04;
    localparam logic [7:0] OFS_FLAGS      = 8'h08;
    localparam logic [7:0] OFS_PARITY     = 8'h0c;
    localparam logic [7:0] OFS_INV_PARITY = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h24;
    // field positions
    localparam int CMD_CLEAR_BIT = 0;
    localparam int FLAG_REC_BIT  = 0;
    localparam int FLAG_CODE_BIT = 1;
    localparam int FLAG_MUL_BIT  = 2;
    // reset values
    localparam logic [1:0]  PAGE_CFG_RST = 2'h0;
    localparam logic [2:0]  FLAGS_RST    = 3'h0;
    localparam logic [15:0] PARITY_RST   = 16'h0000;
    // words per page for each page length select
    localparam logic [3:0][12:0] PAGE_WORDS =
        {13'h1080, 13'h0840, 13'h0420, 13'h0210};
    // word-index bits that take part for each page length
    localparam logic [3:0][11:0] WORD_FIELD_MASK =
        {12'hfff, 12'hfff, 12'h7ff, 12'h3ff};
    // bit-offset bits in use for 16-bit and 8-bit words
    localparam logic [3:0] BIT_FIELD_WIDE   = 4'hf;
    localparam logic [3:0] BIT_FIELD_NARROW = 4'h7;
    // data bits whose bit index has bit k set
    localparam logic [3:0][15:0] COL_MASK =
        {16'hff00, 16'hf0f0, 16'hcccc, 16'haaaa};
endpackage : npec_pkg

// [tb/npec_flash_model.sv]
`timescale 1ns/1ps
// flash side of the data path: streams page words, hands back the saved code
module npec_flash_model (
    // clock
    input  wire logic        clock,
    // word stream toward the checker
    output logic             word_valid,
    output logic [15:0]      word_data,
    // code saved in the spare area, read back
    output logic             code_check,
    output logic [15:0]      stored_parity,
    output logic [15:0]      stored_inv_parity
);
    // idle lines at time zero
    initial begin
        word_valid = 1'b0;
        word_data = 16'h0000;
        code_check = 1'b0;
        stored_parity = 16'h0000;
        stored_inv_parity = 16'h0000;
    end

    // back-to-back words, word j is j*mul, fm xored into word fi
    task automatic send(input int n, input logic [15:0] mul, input int fi, input logic [15:0] fm);
        logic [15:0] d;
        d = 16'h0000;
        for (int j = 0; j < n; j++) begin
            d = 16'(j) * mul ^ ((j == fi) ? fm : 16'h0000);
            @(posedge clock);
            word_valid <= 1'b1;
            word_data <= d;
        end
        @(posedge clock);
        word_valid <= 1'b0;
        word_data <= ~d; // released lines do not keep the last word
    endtask : send

    // code written by the host after the page, returned on read
    task automatic give_code(input logic [15:0] p, input logic [15:0] n);
        @(posedge clock);
        code_check <= 1'b1;
        stored_parity <= p;
        stored_inv_parity <= n;
        @(posedge clock);
        code_check <= 1'b0;
        stored_parity <= ~p;
        stored_inv_parity <= ~n;
    endtask : give_code
endmodule : npec_flash_model

// [tb/tb_nand_page_ecc_checker.sv]
`timescale 1ns/1ps
module tb_nand_page_ecc_checker;
    // design pins
    logic        clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wide_bus, irq;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd, sv;
    logic        word_valid, code_check, clk_en;
    logic [15:0] word_data, stored_parity, stored_inv_parity, p0, n0;
    int          errors, n_checks;
    // select, words before the marker word, expected parity
    typedef struct packed {logic [1:0] sel; logic [15:0] cnt; logic [15:0] par;} npec_row_t;
    npec_row_t rows [7] = '{'{2'h0, 16'h0210, 16'h0000}, '{2'h1, 16'h0210, 16'h2100},
        '{2'h1, 16'h0420, 16'h0000}, '{2'h2, 16'h0420, 16'h4200},
        '{2'h2, 16'h0840, 16'h0000}, '{2'h3, 16'h0840, 16'h8400},
        '{2'h3, 16'h1080, 16'h0000}};

    npec_checker DUT (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .word_valid(word_valid), .word_data(word_data), .wide_bus(wide_bus),
        .code_check(code_check), .stored_parity(stored_parity),
        .stored_inv_parity(stored_inv_parity), .irq(irq));
    npec_flash_model flash (.clock(clock), .word_valid(word_valid), .word_data(word_data),
        .code_check(code_check), .stored_parity(stored_parity),
        .stored_inv_parity(stored_inv_parity));

    // clock, 20 ns period
    always #10 clock = ~clock;

    // verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // compare seen against expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one classic wishbone cycle, read data left in rd
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int k;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        for (k = 0; k < 20; k++) begin
            @(posedge clock);
            if (wb_ack_o === 1'b1) break;
        end
        if (k == 20) begin
            errors++;
            results();
        end else begin
            rd = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end
    endtask : wb

    // expected accumulated code {inverted, parity} of a word stream
    function automatic logic [31:0] code(int n, logic [15:0] mul, int fi, logic [15:0] fm,
                                         logic wide);
        logic [15:0] p, q, d;
        p = 16'h0000;
        q = 16'h0000;
        for (int j = 0; j < n; j++) begin
            d = 16'(j) * mul ^ ((j == fi) ? fm : 16'h0000);
            if (!wide) d[15:8] = 8'h00;
            for (int b = 0; b < 16; b++) if (d[b]) begin
                for (int k = 0; k < 4; k++) if (b[k]) p[k] ^= 1'b1; else q[k] ^= 1'b1;
                for (int i = 0; i < 12; i++) if (j[i]) p[i+4] ^= 1'b1; else q[i+4] ^= 1'b1;
            end
        end
        return {q, p};
    endfunction : code

    // clear, then a six-word page with an optional bad word
    task automatic page(input int fi, input logic [15:0] fm);
        wb(1'b1, npec_pkg::OFS_COMMAND, 32'h0000_0001);
        flash.send(6, 16'h0b1d, fi, fm);
    endtask : page

    // main sequence
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        wide_bus = 1'b1;
        clk_en = 1'b1;
        errors = 0;
        n_checks = 0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        // reset values and an unmapped place
        wb(1'b0, npec_pkg::OFS_PAGE_CFG, 32'h0);
        chk(rd, 32'(npec_pkg::PAGE_CFG_RST));
        wb(1'b0, npec_pkg::OFS_FLAGS, 32'h0);
        chk(rd, 32'(npec_pkg::FLAGS_RST));
        wb(1'b0, npec_pkg::OFS_PARITY, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, npec_pkg::OFS_INV_PARITY, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h0);
        $display("reset test done");
        // page length boundary per select
        foreach (rows[r]) begin
            wb(1'b1, npec_pkg::OFS_PAGE_CFG, {30'h0, rows[r].sel});
            wb(1'b1, npec_pkg::OFS_COMMAND, 32'h0);
            wb(1'b0, npec_pkg::OFS_PARITY, 32'h0);
            chk(rd, (r == 0) ? 32'h0 : {16'h0, rows[r-1].par});
            wb(1'b1, npec_pkg::OFS_COMMAND, 32'h1);
            wb(1'b0, npec_pkg::OFS_PARITY, 32'h0);
            chk(rd, 32'h0);
            flash.send(int'(rows[r].cnt) + 1, 16'h0000, int'(rows[r].cnt), 16'h0001);
            wb(1'b0, npec_pkg::OFS_PARITY, 32'h0);
            chk(rd, {16'h0, rows[r].par});
        end
        $display("page length test done");
        // accumulation in 16-bit and 8-bit mode
        {n0, p0} = code(6, 16'h0b1d, -1, 16'h0, 1'b1);
        page(-1, 16'h0);
        wb(1'b0, npec_pkg::OFS_PARITY, 32'h0);
        chk(rd, {16'h0, p0});
        wb(1'b0, npec_pkg::OFS_INV_PARITY, 32'h0);
        chk(rd, {16'h0, n0});
        wide_bus <= 1'b0;
        page(-1, 16'h0);
        wb(1'b0, npec_pkg::OFS_PARITY, 32'h0);
        wide_bus <= 1'b1;
        sv = code(6, 16'h0b1d, -1, 16'h0, 1'b0);
        chk(rd, {16'h0, sv[15:0]});
        $display("accumulation test done");
        // single data error, interrupt masked then unmasked
        page(2, 16'h0020);
        flash.give_code(p0, n0);
        wb(1'b0, npec_pkg::OFS_FLAGS, 32'h0);
        chk(rd, 32'h1);
        wb(1'b0, npec_pkg::OFS_PARITY, 32'h0);
        chk(rd, 32'h0000_0025);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, npec_pkg::OFS_IRQ_MASK, 32'h7);
        wb(1'b0, npec_pkg::OFS_IRQ_STATUS, 32'h0);
        chk(rd, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, npec_pkg::OFS_IRQ_STATUS, 32'h1);
        wb(1'b0, npec_pkg::OFS_IRQ_STATUS, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("single error test done");
        // one stray bit in the stored code
        page(-1, 16'h0);
        flash.give_code(p0 ^ 16'h0008, n0);
        wb(1'b0, npec_pkg::OFS_FLAGS, 32'h0);
        chk(rd, 32'h3);
        wb(1'b0, npec_pkg::OFS_PARITY, 32'h0);
        sv = rd;
        wb(1'b0, npec_pkg::OFS_INV_PARITY, 32'h0);
        chk(rd | sv, 32'h0000_0008);
        // two bad bits, then clear
        page(2, 16'h0030);
        flash.give_code(p0, n0);
        wb(1'b0, npec_pkg::OFS_FLAGS, 32'h0);
        chk(rd, 32'h5);
        wb(1'b1, npec_pkg::OFS_COMMAND, 32'h1);
        wb(1'b0, npec_pkg::OFS_FLAGS, 32'h0);
        chk(rd, 32'h0);
        $display("code and multiple error test done");
        // words offered while frozen must not count
        clk_en <= 1'b0;
        flash.send(4, 16'h0b1d, -1, 16'h0);
        clk_en <= 1'b1;
        flash.send(6, 16'h0b1d, -1, 16'h0);
        wb(1'b0, npec_pkg::OFS_PARITY, 32'h0);
        chk(rd, {16'h0, p0});
        $display("clock enable test done");
        // reset in mid-run drops irq and codes
        chk({31'h0, irq}, 32'h1);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, wb_ack_o}, 32'h0);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        wb(1'b0, npec_pkg::OFS_PARITY, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, npec_pkg::OFS_IRQ_MASK, 32'h0);
        chk(rd, 32'h0);
        $display("mid-run reset test done");
        results();
    end
endmodule : tb_nand_page_ecc_checker
